// ---- crs_top.sv ----
// conversion ready signalling, filter restart and serial readout of a converter
//
// Behaviour
// - restart low clears filter, control, calibration, modulator
// - restart never touches the serial readout logic
// - restart forces the ready indication high
// - ready pin low when a new result exists
// - unread result: ready returns high before next update
// - ready falling edge only for completed conversions
// - shift register loads data or selected control register
// - bits change on serial clock falling edge
// - continuous or burst serial clock both work
`timescale 1ns/10ps
module crs_top #(
  parameter int DATA_W = crs_pkg::CRS_DATA_W,
  parameter int DECIM = crs_pkg::CRS_DECIM,
  parameter int SETTLE_CONVS = crs_pkg::CRS_SETTLE_CONVS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic filter_restart_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mod_bit,
  input wire logic read_req,
  input wire logic read_sel,
  input wire logic [DATA_W-1:0] ctrl_reg_value,
  output logic serial_out_ready_pin,
  output logic serial_out_ready_oe_n,
  output logic conversion_done_n,
  output logic [DATA_W-1:0] conv_data,
  output logic modulator_reset,
  output logic filter_ctrl_reset,
  output logic cal_ctrl_reset
);
  import crs_pkg::*;

  localparam int DEC_W = (DECIM > 1) ? $clog2(DECIM) : 1;
  localparam int BIT_W = $clog2(DATA_W + 1);
  localparam int SET_W = $clog2(SETTLE_CONVS + 1);
  localparam logic [DEC_W-1:0] DEC_LAST = DEC_W'(DECIM - 1);
  localparam logic [DEC_W-1:0] DEC_RDY_HIGH = DEC_W'(DECIM - 1 - CRS_RDY_LEAD_CYCLES);
  localparam logic [SET_W-1:0] SET_LAST = SET_W'(SETTLE_CONVS - 1);

  typedef struct packed {
    crs_phase_type phase;
    logic [DEC_W-1:0] dec_cnt;
    logic [DATA_W-1:0] acc;
    logic [SET_W-1:0] settle_cnt;
    logic [DATA_W-1:0] data;
    logic rdy_n;
    logic sclk_prev;
    logic [DATA_W-1:0] shift;
    logic [BIT_W-1:0] bit_cnt;
    logic tail;
    logic reading_data;
    logic pin;
  } crs_state_type;

  localparam crs_state_type STATE_RESET = '{
    phase: CRS_PH_HOLD,
    dec_cnt: '0,
    acc: '0,
    settle_cnt: '0,
    data: '0,
    rdy_n: CRS_RDY_RESET,
    sclk_prev: 1'b1,
    shift: '0,
    bit_cnt: '0,
    tail: 1'b0,
    reading_data: 1'b0,
    pin: CRS_RDY_RESET
  };

  crs_state_type st_reg;
  crs_state_type st_next;
  logic [CRS_SYNC_W-1:0] pins_sync;
  logic restart_n_s;
  logic sclk_s;
  logic cs_n_s;
  logic sclk_fall;
  logic busy;
  logic [DATA_W-1:0] result;

  crs_sync2 #(
    .WIDTH(CRS_SYNC_W),
    .RESET_VAL(CRS_SYNC_RESET)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({filter_restart_n, sclk, cs_n}),
    .sync_out(pins_sync)
  );

  assign restart_n_s = pins_sync[2];
  assign sclk_s = pins_sync[1];
  assign cs_n_s = pins_sync[0];

  always_comb
  begin
    st_next = st_reg;
    st_next.sclk_prev = sclk_s;
    // the edge is found in sys_clk, so any burst pattern or idle gap is fine
    sclk_fall = st_reg.sclk_prev & ~sclk_s;
    busy = (st_reg.bit_cnt != '0) | st_reg.tail;
    result = st_reg.acc + {{(DATA_W-1){1'b0}}, mod_bit};

    // readout side: deliberately independent of the restart input
    if (cs_n_s)
    begin
      st_next.bit_cnt = '0;
      st_next.tail = 1'b0;
      st_next.reading_data = 1'b0;
    end
    else if (!busy && read_req)
    begin
      st_next.shift = (read_sel == CRS_SEL_CTRL) ? ctrl_reg_value : st_reg.data;
      st_next.bit_cnt = BIT_W'(DATA_W);
      st_next.reading_data = (read_sel == CRS_SEL_DATA);
    end
    else if (sclk_fall)
    begin
      if (st_reg.bit_cnt != '0)
      begin
        st_next.pin = st_reg.shift[DATA_W-1];
        st_next.shift = {st_reg.shift[DATA_W-2:0], 1'b0};
        st_next.bit_cnt = st_reg.bit_cnt - 1'b1;
        if (st_reg.bit_cnt == BIT_W'(1))
        begin
          st_next.tail = 1'b1;
          // a result that has been read is no longer new
          if (st_reg.reading_data)
          begin
            st_next.rdy_n = 1'b1;
          end
        end
      end
      else
      begin
        st_next.tail = 1'b0;
        st_next.reading_data = 1'b0;
      end
    end

    // conversion side
    if (!restart_n_s)
    begin
      st_next.phase = CRS_PH_HOLD;
      st_next.dec_cnt = '0;
      st_next.acc = '0;
      st_next.settle_cnt = '0;
      st_next.rdy_n = 1'b1;
    end
    else
    begin
      st_next.dec_cnt = (st_reg.dec_cnt == DEC_LAST) ? '0 : st_reg.dec_cnt + 1'b1;
      st_next.acc = (st_reg.dec_cnt == DEC_LAST) ? '0 : result;
      // withdraw an unread result shortly before it is replaced
      if (st_reg.phase == CRS_PH_RUN && st_reg.dec_cnt == DEC_RDY_HIGH)
      begin
        st_next.rdy_n = 1'b1;
      end
      unique case (st_reg.phase)
        CRS_PH_HOLD:
        begin
          st_next.phase = CRS_PH_SETTLE;
          st_next.dec_cnt = '0;
          st_next.acc = '0;
        end
        CRS_PH_SETTLE:
        begin
          if (st_reg.dec_cnt == DEC_LAST)
          begin
            st_next.settle_cnt = st_reg.settle_cnt + 1'b1;
            if (st_reg.settle_cnt == SET_LAST)
            begin
              st_next.phase = CRS_PH_RUN;
            end
          end
        end
        CRS_PH_RUN:
        begin
        end
        default:
        begin
          st_next.phase = CRS_PH_HOLD;
        end
      endcase
      // a read-complete clear wins over a new result in the same cycle; that result is dropped
      if (st_reg.dec_cnt == DEC_LAST &&
          (st_reg.phase == CRS_PH_RUN ||
           (st_reg.phase == CRS_PH_SETTLE && st_reg.settle_cnt == SET_LAST)))
      begin
        // the data register is frozen while it is being shifted out
        if (!(busy && st_reg.reading_data))
        begin
          st_next.data = result;
          st_next.rdy_n = 1'b0;
        end
      end
    end

    // outside a word the pin follows the ready indication
    if (!st_next.tail && st_next.bit_cnt == '0 && !(busy && !sclk_fall))
    begin
      st_next.pin = st_next.rdy_n;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= STATE_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign serial_out_ready_pin = st_reg.pin;
  assign serial_out_ready_oe_n = cs_n_s;
  assign conversion_done_n = st_reg.rdy_n;
  assign conv_data = st_reg.data;
  assign modulator_reset = (st_reg.phase == CRS_PH_HOLD);
  assign filter_ctrl_reset = (st_reg.phase == CRS_PH_HOLD);
  assign cal_ctrl_reset = (st_reg.phase == CRS_PH_HOLD);
endmodule : crs_top

// ---- crs_pkg.sv ----
// constants and types shared by the conversion ready and sync block
package crs_pkg;
  localparam int CRS_DATA_W = 24;
  localparam int CRS_DECIM = 64;
  localparam int CRS_SETTLE_CONVS = 4;
  localparam int CRS_RDY_LEAD_CYCLES = 2;
  localparam int CRS_SYNC_W = 3;
  localparam logic [2:0] CRS_SYNC_RESET = 3'h7;
  localparam logic CRS_RDY_RESET = 1'h1;
  localparam logic CRS_SEL_DATA = 1'h0;
  localparam logic CRS_SEL_CTRL = 1'h1;

  typedef enum logic [1:0] {
    CRS_PH_HOLD = 2'b00,
    CRS_PH_SETTLE = 2'b01,
    CRS_PH_RUN = 2'b10
  } crs_phase_type;
endpackage : crs_pkg

// ---- crs_sync2.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module crs_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : crs_sync2

// ---- crs_monitor.sv ----
// assertion checker for the conversion ready and sync block
`timescale 1ns/10ps
module crs_monitor #(
  parameter int DECIM = 64
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic filter_restart_n,
  input wire logic cs_n,
  input wire logic serial_out_ready_oe_n,
  input wire logic conversion_done_n,
  input wire logic modulator_reset,
  input wire logic filter_ctrl_reset,
  input wire logic cal_ctrl_reset
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // four samples leave room for the two synchroniser stages
  property p_hold;
    !filter_restart_n [*4] |=> modulator_reset && filter_ctrl_reset && cal_ctrl_reset;
  endproperty
  a_hold: assert property (p_hold) else $error("restart hold lost");
  property p_force;
    !filter_restart_n [*4] |=> conversion_done_n;
  endproperty
  a_force: assert property (p_force) else $error("ready not forced high");
  property p_lapse;
    $fell(conversion_done_n) |-> ##[1:DECIM] conversion_done_n;
  endproperty
  a_lapse: assert property (p_lapse) else $error("ready not withdrawn");
  property p_only;
    $fell(conversion_done_n) |-> !modulator_reset && !filter_ctrl_reset;
  endproperty
  a_only: assert property (p_only) else $error("ready while held");
  property p_settle;
    !filter_restart_n [*4] ##1 filter_restart_n |=> conversion_done_n [*8];
  endproperty
  a_settle: assert property (p_settle) else $error("ready before settling");
  property p_free;
    (modulator_reset && !cs_n) [*3] |-> !serial_out_ready_oe_n;
  endproperty
  a_free: assert property (p_free) else $error("serial side disturbed");
  property p_desel;
    cs_n [*3] |-> serial_out_ready_oe_n;
  endproperty
  a_desel: assert property (p_desel) else $error("pin driven unselected");
  property p_rel;
    $fell(modulator_reset) |-> !filter_ctrl_reset && !cal_ctrl_reset;
  endproperty
  a_rel: assert property (p_rel) else $error("resets released apart");
endmodule : crs_monitor
bind crs_top crs_monitor #(.DECIM(DECIM)) u_mon (.sys_clk(sys_clk), .rst(rst),
  .filter_restart_n(filter_restart_n), .cs_n(cs_n), .serial_out_ready_oe_n(serial_out_ready_oe_n),
  .conversion_done_n(conversion_done_n), .modulator_reset(modulator_reset),
  .filter_ctrl_reset(filter_ctrl_reset), .cal_ctrl_reset(cal_ctrl_reset));

// ---- crs_host_model.sv ----
// serial host model: drives select and serial clock, samples the shared pin
`timescale 1ns/10ps
module crs_host_model (
  output logic sclk,
  output logic cs_n,
  input wire logic pin
);
  initial
  begin
    sclk = 1'h1;
    cs_n = 1'h1;
  end
  // clock stands high between frames; burst mode pauses after each byte
  task automatic read_word(input bit burst, output logic [23:0] w);
    w = 24'h0;
    cs_n = 1'h0;
    #400;
    for (int i = 0; i < 25; i++)
    begin
      #100 sclk = 1'h0;
      #100 sclk = 1'h1;
      if (i < 24) w = {w[22:0], pin};
      if (burst && i % 8 == 7) #700;
    end
    #300 cs_n = 1'h1;
    // deselect must stand long enough to be seen before the next frame
    #200;
  endtask : read_word
endmodule : crs_host_model

// ---- conversion_ready_and_sync_bench.sv ----
// self-checking bench for the conversion ready and sync block
`timescale 1ns/10ps
module conversion_ready_and_sync_bench;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic frn = 1'h1;
  logic mod_bit = 1'h0;
  logic req = 1'h0;
  logic sel = 1'h0;
  logic sclk, cs_n, pin, line, oe_n, done_n, prev_done, mr, fr, cr;
  logic [23:0] ctrl = 24'h0;
  logic [23:0] conv, exp_res, w;
  int n_errors = 0;
  int num_checks = 0;
  int hist[$];
  always #12.5 sys_clk = ~sys_clk;
  // a released line shows the inverse so a stale bit cannot pass
  assign line = oe_n ? ~pin : pin;
  crs_top #(.DECIM(8), .SETTLE_CONVS(2)) u_dut (.sys_clk(sys_clk), .rst(rst),
    .filter_restart_n(frn), .sclk(sclk), .cs_n(cs_n), .mod_bit(mod_bit), .read_req(req),
    .read_sel(sel), .ctrl_reg_value(ctrl), .serial_out_ready_pin(pin),
    .serial_out_ready_oe_n(oe_n), .conversion_done_n(done_n), .conv_data(conv),
    .modulator_reset(mr), .filter_ctrl_reset(fr), .cal_ctrl_reset(cr));
  crs_host_model u_host (.sclk(sclk), .cs_n(cs_n), .pin(line));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // sinc1 model: each result is the count of ones over the last eight samples
  always @(posedge sys_clk)
  begin
    mod_bit <= 1'($urandom);
    if (done_n === 1'h0 && prev_done === 1'h1)
    begin
      exp_res = 24'(hist.sum());
      chk(conv, exp_res);
    end
    prev_done = done_n;
    hist.push_back(int'(mod_bit));
    if (hist.size() > 8)
      void'(hist.pop_front());
  end
  task automatic wait_rdy();
    logic last;
    last = 1'h0;
    for (int k = 0; k < 200 && !(last === 1'h1 && done_n === 1'h0); k++)
    begin
      last = done_n;
      @(posedge sys_clk);
      #1;
    end
    // the shared pin must show the ready level together with the ready flag
    chk(24'({pin, done_n}), 24'h0);
  endtask : wait_rdy
  task automatic rd(input logic s, input bit burst);
    logic [23:0] e;
    e = 24'h0;
    fork
      u_host.read_word(burst, w);
      begin
        repeat (3) @(posedge sys_clk);
        sel <= s;
        req <= 1'h1;
        @(posedge sys_clk);
        req <= 1'h0;
        // latch what was loaded: newer results land after the word, before the check
        e = s ? ctrl : exp_res;
      end
    join
    chk(w, e);
  endtask : rd
  initial
  begin
    void'($urandom(32'he341b8a0));
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    for (int i = 0; i < 4; i++)
    begin
      ctrl <= 24'($urandom);
      wait_rdy();
      rd(1'h0, i[0]);
      rd(1'h1, i[1]);
    end
    fork
      rd(1'h1, 1'h0);
      begin
        repeat (40) @(posedge sys_clk);
        frn <= 1'h0;
        repeat (6) @(posedge sys_clk);
        frn <= 1'h1;
        #1 chk(24'({mr, fr, cr, done_n}), 24'hf);
      end
    join
    wait_rdy();
    rd(1'h0, 1'h1);
    conclude();
  end
  initial
  begin
    #300000;
    n_errors++;
    conclude();
  end
endmodule : conversion_ready_and_sync_bench
